// [hdl/pmt_regs.svh]
`ifndef PMT_REGS_SVH
`define PMT_REGS_SVH
// How it works
// - Timer runs from instruction clock through prescaler
// - Counter counts up from zero each tick
// - Prescaler divides by 1, 4 or 16
// - Count equal to period gives match pulse
// - Match zeroes counter and steps postscaler
// - Software reads and writes count and period
// - Reset clears count, period becomes all ones
// - Resets and count/control writes clear scalers
// - Control write keeps the count value
// - Postscaler completion sets sticky match flag
// - Postscale ratio 1:1 to 1:16
// - Interrupt only while match enable set
// - Unscaled match goes to capture/PWM units
// - Match can clock the serial port
// - Sleep stops counting, values hold

// Register byte offsets
`define PMT_OFS_COUNT   8'h00
`define PMT_OFS_PERIOD  8'h04
`define PMT_OFS_CONTROL 8'h08
`define PMT_OFS_STATUS  8'h0C
`define PMT_OFS_MASK    8'h10
// Control field positions
`define PMT_CTL_PRE_LSB  0
`define PMT_CTL_PRE_MSB  1
`define PMT_CTL_ON_BIT   2
`define PMT_CTL_POST_LSB 3
`define PMT_CTL_POST_MSB 6
// Status and mask field position
`define PMT_IRQ_MATCH_BIT 0
// Reset values
`define PMT_RST_COUNT   8'h00
`define PMT_RST_PERIOD  8'hFF
`define PMT_RST_CONTROL 7'h00
// Oscillator cycles per instruction cycle
`define PMT_OSC_PER_INSTR 4
`endif

// [hdl/pmt_pkg.sv]
package pmt_pkg;
  // Prescaler ratio select
  typedef enum logic [1:0] {
    PMT_DIV1,
    PMT_DIV4,
    PMT_DIV16,
    PMT_DIV16_ALT
  } pmt_prescale_type;
  // Byte wide timer value
  typedef logic [7:0] pmt_byte_type;
endpackage : pmt_pkg

// [hdl/pmt_prescaler.sv]
module pmt_prescaler
  import pmt_pkg::*;
(
  input  wire logic                      ref_clk,  // Clock
  input  wire logic                      resetn,   // Sync reset
  input  wire logic                      clkEn,    // Clock enable
  input  wire logic                      clear,    // Zero the divider
  input  wire logic                      tickIn,   // Instruction tick
  input  wire pmt_pkg::pmt_prescale_type sel,      // Ratio select
  output logic                           tickOut   // Divided tick
);
  import pmt_pkg::*;

  logic [3:0] cnt_r;  // Divider count
  logic [3:0] cnt_nxt;
  logic [3:0] mask;   // Terminal pattern

  // ***************************************************
  // Ratio decode and next count
  // ***************************************************
  always_comb begin
    unique case (sel)
      PMT_DIV1: mask = 4'h0;  // Direct input
      PMT_DIV4: mask = 4'h3;
      default:  mask = 4'hF;  // Both upper codes divide by 16
    endcase
    tickOut = tickIn && ((cnt_r & mask) == mask);
    cnt_nxt = cnt_r;
    if (clear) begin
      cnt_nxt = 4'h0;
    end else if (tickIn) begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end

  // Register the divider
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_r <= 4'h0;
    end else if (clkEn) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : pmt_prescaler

// [hdl/pmt_postscaler.sv]
module pmt_postscaler (
  input  wire logic       ref_clk,  // Clock
  input  wire logic       resetn,   // Sync reset
  input  wire logic       clkEn,    // Clock enable
  input  wire logic       clear,    // Zero the counter
  input  wire logic       matchIn,  // Unscaled match
  input  wire logic [3:0] sel,      // Ratio minus one
  output logic            done      // One pulse per sel+1 matches
);
  logic [3:0] cnt_r;  // Matches seen
  logic [3:0] cnt_nxt;

  // ***************************************************
  // Count matches, wrap at the selected ratio
  // ***************************************************
  always_comb begin
    done    = matchIn && (cnt_r >= sel);
    cnt_nxt = cnt_r;
    if (clear) begin
      cnt_nxt = 4'h0;
    end else if (done) begin
      cnt_nxt = 4'h0;
    end else if (matchIn) begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end

  // Register the counter
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_r <= 4'h0;
    end else if (clkEn) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : pmt_postscaler

// [hdl/pmt_timer.sv]
// Local design decisions: the address map and the APB slave port.
`include "pmt_regs.svh"

module pmt_timer (
  input  wire logic        ref_clk,      // 50 MHz oscillator clock
  input  wire logic        resetn,       // Sync device reset
  input  wire logic        clkEn,        // Freezes all state when low
  input  wire logic        sleepMode,    // Processor asleep
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB direction
  input  wire logic [7:0]  paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error
  output logic             matchPulse,   // Unscaled match
  output logic             spiShiftClk,  // Serial port shift clock
  output logic             irq           // Level interrupt
);
  import pmt_pkg::*;

  // ***************************************************
  // Declarations
  // ***************************************************
  logic [1:0]       phase_r;       // Oscillator phase
  logic [1:0]       phase_nxt;
  logic             instrTick;     // One per instruction cycle
  pmt_byte_type     count_r;       // Timer count
  pmt_byte_type     count_nxt;
  pmt_byte_type     period_r;      // Period value
  pmt_byte_type     period_nxt;
  pmt_prescale_type preSel_r;      // Prescale select
  pmt_prescale_type preSel_nxt;
  logic             timerOn_r;     // Run enable
  logic             timerOn_nxt;
  logic [3:0]       postSel_r;     // Postscale select
  logic [3:0]       postSel_nxt;
  logic             irqFlag_r;     // Sticky match flag
  logic             irqFlag_nxt;
  logic             irqEn_r;       // Match interrupt enable
  logic             irqEn_nxt;
  logic [31:0]      prdata_r;      // Read data register
  logic [31:0]      prdata_nxt;
  logic             match_r;       // Registered match
  logic             match_nxt;
  logic             spiClk_r;      // Shift clock toggle
  logic             spiClk_nxt;
  logic             running;       // Tick allowed to prescaler
  logic             cntTick;       // Prescaled counter tick
  logic             isMatch;       // Count equals period
  logic             postDone;      // Postscaler completion
  logic             apbWr;         // Write in access phase
  logic             apbSetup;      // Setup phase
  logic             wrCount;       // Write to count
  logic             wrPeriod;      // Write to period
  logic             wrCtrl;        // Write to control
  logic             wrStatus;      // Write to status
  logic             wrMask;        // Write to mask
  logic             scalerClr;     // Clears both scalers

  // Decode whether a byte address holds a register
  function automatic logic addrValid(input logic [7:0] a);
    addrValid = (a == `PMT_OFS_COUNT)   || (a == `PMT_OFS_PERIOD) ||
                (a == `PMT_OFS_CONTROL) || (a == `PMT_OFS_STATUS) ||
                (a == `PMT_OFS_MASK);
  endfunction : addrValid

  // ***************************************************
  // APB decode
  // ***************************************************
  always_comb begin
    apbSetup  = psel && !penable;
    apbWr     = psel && penable && pwrite && addrValid(paddr);
    wrCount   = apbWr && (paddr == `PMT_OFS_COUNT);
    wrPeriod  = apbWr && (paddr == `PMT_OFS_PERIOD);
    wrCtrl    = apbWr && (paddr == `PMT_OFS_CONTROL);
    wrStatus  = apbWr && (paddr == `PMT_OFS_STATUS);
    wrMask    = apbWr && (paddr == `PMT_OFS_MASK);
    scalerClr = wrCount || wrCtrl;
    pready    = 1'b1;               // Always zero wait states
    pslverr   = psel && penable && !addrValid(paddr);
  end

  // ***************************************************
  // Instruction clock from oscillator
  // ***************************************************
  always_comb begin
    phase_nxt = phase_r + 2'd1;
    instrTick = (phase_r == 2'(`PMT_OSC_PER_INSTR - 1));
    // Sleep stops the timer clock
    running   = instrTick && timerOn_r && !sleepMode;
  end

  // Register phase
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      phase_r <= 2'd0;
    end else if (clkEn) begin
      phase_r <= phase_nxt;
    end
  end

  // ***************************************************
  // Prescaler and postscaler
  // ***************************************************
  pmt_prescaler u_pre (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clkEn   (clkEn),
    .clear   (scalerClr),
    .tickIn  (running),
    .sel     (preSel_r),
    .tickOut (cntTick)
  );

  // Match compare on every counter tick
  assign isMatch = cntTick && (count_r == period_r);

  pmt_postscaler u_post (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clkEn   (clkEn),
    .clear   (scalerClr),
    .matchIn (isMatch),
    .sel     (postSel_r),
    .done    (postDone)
  );

  // ***************************************************
  // Counter, period and control next values
  // ***************************************************
  always_comb begin
    count_nxt   = count_r;
    period_nxt  = period_r;
    preSel_nxt  = preSel_r;
    timerOn_nxt = timerOn_r;
    postSel_nxt = postSel_r;
    if (wrCount) begin
      count_nxt = pwdata[7:0];
    end else if (isMatch) begin
      count_nxt = `PMT_RST_COUNT;
    end else if (cntTick) begin
      count_nxt = count_r + 8'h01;
    end
    // Period only changes by software
    if (wrPeriod) begin
      period_nxt = pwdata[7:0];
    end
    // Control write leaves the count alone
    if (wrCtrl) begin
      preSel_nxt  = pmt_prescale_type'(
        pwdata[`PMT_CTL_PRE_MSB:`PMT_CTL_PRE_LSB]);
      timerOn_nxt = pwdata[`PMT_CTL_ON_BIT];
      postSel_nxt = pwdata[`PMT_CTL_POST_MSB:`PMT_CTL_POST_LSB];
    end
  end

  // Register counter, period and control
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      count_r   <= `PMT_RST_COUNT;
      period_r  <= `PMT_RST_PERIOD;
      preSel_r  <= PMT_DIV1;
      timerOn_r <= 1'b0;
      postSel_r <= 4'h0;
    end else if (clkEn) begin
      count_r   <= count_nxt;
      period_r  <= period_nxt;
      preSel_r  <= preSel_nxt;
      timerOn_r <= timerOn_nxt;
      postSel_r <= postSel_nxt;
    end
  end

  // ***************************************************
  // Interrupt flag, enable and match outputs
  // ***************************************************
  always_comb begin
    irqFlag_nxt = irqFlag_r;
    irqEn_nxt   = irqEn_r;
    // Write one clears, but a new completion wins
    if (wrStatus && pwdata[`PMT_IRQ_MATCH_BIT]) begin
      irqFlag_nxt = 1'b0;
    end
    if (postDone) begin
      irqFlag_nxt = 1'b1;
    end
    if (wrMask) begin
      irqEn_nxt = pwdata[`PMT_IRQ_MATCH_BIT];
    end
    match_nxt  = isMatch;
    // Serial shift clock is match divided by two
    spiClk_nxt = spiClk_r ^ isMatch;
  end

  // Register flag, enable and match outputs
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irqFlag_r <= 1'b0;
      irqEn_r   <= 1'b0;
      match_r   <= 1'b0;
      spiClk_r  <= 1'b0;
    end else if (clkEn) begin
      irqFlag_r <= irqFlag_nxt;
      irqEn_r   <= irqEn_nxt;
      match_r   <= match_nxt;
      spiClk_r  <= spiClk_nxt;
    end
  end

  assign matchPulse  = match_r;
  assign spiShiftClk = spiClk_r;
  assign irq         = irqFlag_r && irqEn_r;

  // ***************************************************
  // Read data, captured in the setup phase
  // ***************************************************
  always_comb begin
    prdata_nxt = prdata_r;
    if (apbSetup) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        `PMT_OFS_COUNT:   prdata_nxt[7:0] = count_r;
        `PMT_OFS_PERIOD:  prdata_nxt[7:0] = period_r;
        `PMT_OFS_CONTROL: begin
          prdata_nxt[`PMT_CTL_PRE_MSB:`PMT_CTL_PRE_LSB]   = preSel_r;
          prdata_nxt[`PMT_CTL_ON_BIT]                     = timerOn_r;
          prdata_nxt[`PMT_CTL_POST_MSB:`PMT_CTL_POST_LSB] = postSel_r;
        end
        `PMT_OFS_STATUS:  prdata_nxt[`PMT_IRQ_MATCH_BIT] = irqFlag_r;
        `PMT_OFS_MASK:    prdata_nxt[`PMT_IRQ_MATCH_BIT] = irqEn_r;
        default:          prdata_nxt = 32'h0000_0000;  // Unmapped
      endcase
    end
  end

  // Register read data
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (clkEn) begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Match taken with the clock running
  sequence s_match;
    clkEn && isMatch && !wrCount;
  endsequence

  // Plain counting tick
  sequence s_step;
    clkEn && cntTick && !isMatch && !wrCount;
  endsequence

  property p_instr_rate;
    clkEn && instrTick ##1 clkEn ##1 clkEn |-> !instrTick;
  endproperty
  a_instr_rate: assert property (p_instr_rate)
    else $error("instruction tick too frequent");

  property p_count_step;
    s_step |=> count_r == $past(count_r) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not step by one");

  property p_match_pulse;
    s_match |=> matchPulse;
  endproperty
  a_match_pulse: assert property (p_match_pulse)
    else $error("match pulse missing");

  property p_match_wrap;
    s_match |=> count_r == 8'h00;
  endproperty
  a_match_wrap: assert property (p_match_wrap)
    else $error("counter not zeroed after match");

  property p_reset_vals;
    @(posedge ref_clk) disable iff (1'b0)
      !resetn |=> count_r == 8'h00 && period_r == 8'hFF;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("bad reset values");

  property p_ctrl_keeps;
    clkEn && wrCtrl && !cntTick |=> $stable(count_r);
  endproperty
  a_ctrl_keeps: assert property (p_ctrl_keeps)
    else $error("control write changed count");

  property p_post_flag;
    clkEn && postDone |=> irqFlag_r;
  endproperty
  a_post_flag: assert property (p_post_flag)
    else $error("flag not set on completion");

  property p_irq_gate;
    irqFlag_r && !irqEn_r |-> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt while disabled");

  property p_sleep_hold;
    sleepMode && clkEn && !apbWr |=> $stable(count_r) && $stable(period_r);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("timer moved during sleep");

  property p_flag_sticky;
    irqFlag_r && !wrStatus [*2] |=> irqFlag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag dropped without clear");

  property p_spi_toggle;
    clkEn && isMatch |=> spiShiftClk != $past(spiShiftClk);
  endproperty
  a_spi_toggle: assert property (p_spi_toggle)
    else $error("shift clock did not toggle");

  // Count or control write leaves both scalers at zero
  property p_scaler_clr;
    clkEn && scalerClr |=> u_pre.cnt_r == 4'h0 && u_post.cnt_r == 4'h0;
  endproperty
  a_scaler_clr: assert property (p_scaler_clr)
    else $error("scalers not cleared by write");

endmodule : pmt_timer

// [tb/pmt_timer_tb.sv]
`include "pmt_regs.svh"

// Compare two values, count it, report a mismatch at once
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
  errTotal++; $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); \
  end end

module pmt_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ********************************************************
  // Signals
  // ********************************************************
  logic        ref_clk;      // 50 MHz clock
  logic        resetn;       // Sync reset
  logic        clkEn;        // Clock enable
  logic        sleepMode;    // Processor asleep
  logic        psel;         // APB select
  logic        penable;      // APB enable
  logic        pwrite;       // APB direction
  logic [7:0]  paddr;        // APB address
  logic [31:0] pwdata;       // APB write data
  logic [31:0] prdata;       // APB read data
  logic        pready;       // APB ready
  logic        pslverr;      // APB error
  logic        matchPulse;   // Unscaled match
  logic        spiShiftClk;  // Serial shift clock
  logic        irq;          // Interrupt
  int          errTotal;     // Mismatches
  int          checked;      // Comparisons
  int          ratio [4] = '{1, 4, 16, 16};  // Prescale by select code

  pmt_timer dut (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .clkEn      (clkEn),
    .sleepMode  (sleepMode),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .matchPulse (matchPulse),
    .spiShiftClk(spiShiftClk),
    .irq        (irq)
  );

  // Free running clock, 20 ns period
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ********************************************************
  // Common tasks
  // ********************************************************
  // Verdict and end of run
  task test_done;
    $display("Comparisons %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // One APB transfer; holds the request until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errTotal++;
      test_done();
    end
  endtask : apb

  // Register write, error flag must stay low
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    `CHK(e, 1'b0)
  endtask : wr

  // Register read, error flag must stay low
  task rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    `CHK(e, 1'b0)
  endtask : rd

  // Cycles until the next match pulse, bounded
  task wait_match(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (matchPulse !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      errTotal++;
      test_done();
    end
  endtask : wait_match

  // ********************************************************
  // Scenarios
  // ********************************************************
  // Reset, then every register at its reset value
  task sc_reset;
    logic [31:0] q;
    logic [7:0]  ofs [5] = '{`PMT_OFS_COUNT, `PMT_OFS_PERIOD,
      `PMT_OFS_CONTROL, `PMT_OFS_STATUS, `PMT_OFS_MASK};
    logic [31:0] exp [5] = '{32'h0000_0000, 32'h0000_00FF,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    resetn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], q);
      `CHK(q, exp[i])
    end
    `CHK(irq, 1'b0)
  endtask : sc_reset

  // Read back, control write keeps count, unmapped access refused
  task sc_regs;
    logic [31:0] q;
    logic        e;
    wr(`PMT_OFS_COUNT, 32'h0000_0042);
    wr(`PMT_OFS_CONTROL, 32'h0000_0001);
    rd(`PMT_OFS_COUNT, q);
    `CHK(q, 32'h0000_0042)
    wr(`PMT_OFS_PERIOD, 32'h0000_00A5);
    rd(`PMT_OFS_PERIOD, q);
    `CHK(q, 32'h0000_00A5)
    apb(1'b0, 8'h14, 32'h0000_0000, q, e);
    `CHK({e, q}, {1'b1, 32'h0000_0000})
  endtask : sc_regs

  // Match spacing for each prescale code; shift clock toggles
  task sc_prescale;
    int   n;
    logic s;
    wr(`PMT_OFS_COUNT, 32'h0000_0000);
    wr(`PMT_OFS_PERIOD, 32'h0000_0003);
    for (int p = 0; p < 4; p++) begin
      wr(`PMT_OFS_CONTROL, 32'h0000_0004 | p);
      // First interval may straddle the ratio change, so skip it
      wait_match(n);
      wait_match(n);
      wait_match(n);
      `CHK(n, 4 * 4 * ratio[p])
      repeat (2) @(posedge ref_clk);
      s = spiShiftClk;
      wait_match(n);
      repeat (2) @(posedge ref_clk);
      `CHK(spiShiftClk, ~s)
    end
  endtask : sc_prescale

  // Flag on the (p+1)th match only, gated by the mask
  task sc_post(input int p);
    int          n;
    logic [31:0] q;
    wr(`PMT_OFS_CONTROL, 32'h0000_0000);
    wr(`PMT_OFS_PERIOD, 32'h0000_0001);
    wr(`PMT_OFS_STATUS, 32'h0000_0001);
    wr(`PMT_OFS_MASK, 32'h0000_0001);
    wr(`PMT_OFS_COUNT, 32'h0000_0000);
    `CHK(irq, 1'b0)
    wr(`PMT_OFS_CONTROL, 32'h0000_0004 | (p << 3));
    for (int i = 1; i <= p + 1; i++) begin
      wait_match(n);
      repeat (3) @(posedge ref_clk);
      `CHK(irq, 1'(i == p + 1))
    end
    wait_match(n);
    rd(`PMT_OFS_STATUS, q);
    `CHK(q, 32'h0000_0001)
    wr(`PMT_OFS_MASK, 32'h0000_0000);
    // Enable drops at the access edge; look one edge later
    @(posedge ref_clk);
    `CHK(irq, 1'b0)
    wr(`PMT_OFS_CONTROL, 32'h0000_0000);
    wr(`PMT_OFS_STATUS, 32'h0000_0001);
    rd(`PMT_OFS_STATUS, q);
    `CHK(q, 32'h0000_0000)
  endtask : sc_post

  // Counting from zero, held in sleep and while clock enable is low
  task sc_sleep;
    logic [31:0] a;
    logic [31:0] b;
    wr(`PMT_OFS_PERIOD, 32'h0000_00FF);
    wr(`PMT_OFS_COUNT, 32'h0000_0000);
    wr(`PMT_OFS_CONTROL, 32'h0000_0004);
    repeat (40) @(posedge ref_clk);
    rd(`PMT_OFS_COUNT, a);
    `CHK(1'(a >= 8 && a <= 13), 1'b1)
    sleepMode <= 1'b1;
    rd(`PMT_OFS_COUNT, a);
    repeat (40) @(posedge ref_clk);
    rd(`PMT_OFS_COUNT, b);
    `CHK(b, a)
    rd(`PMT_OFS_PERIOD, b);
    `CHK(b, 32'h0000_00FF)
    sleepMode <= 1'b0;
    rd(`PMT_OFS_COUNT, a);
    clkEn <= 1'b0;
    repeat (40) @(posedge ref_clk);
    clkEn <= 1'b1;
    rd(`PMT_OFS_COUNT, b);
    `CHK(1'(b - a <= 3), 1'b1)
  endtask : sc_sleep

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    errTotal  = 0;
    checked   = 0;
    resetn    = 1'b0;
    clkEn     = 1'b1;
    sleepMode = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    sc_reset();
    sc_regs();
    sc_prescale();
    sc_post(0);
    sc_post(15);
    sc_sleep();
    // Second reset while the timer runs
    sc_reset();
    test_done();
  end
endmodule : pmt_timer_tb
